// ==== sar_adc_control.sv ====
// converter control block: APB registers, sequencer, compare and interrupt
// assumes the SAR core returns a result word valid at end of conversion, on this clock
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module sar_adc_control (
  input  wire logic                       CLOCK_I,
  input  wire logic                       SYS_RST_I,
  input  wire logic                       PSEL_I,
  input  wire logic                       PENABLE_I,
  input  wire logic                       PWRITE_I,
  input  wire logic [11:0]                PADDR_I,
  input  wire logic [31:0]                PWDATA_I,
  input  wire logic [3:0]                 PSTRB_I,
  output logic      [31:0]                PRDATA_O,
  output logic                            PREADY_O,
  output logic                            PSLVERR_O,
  input  wire logic                       POWER_DOWN_I,
  input  wire logic [9:0]                 CORE_RESULT_I,
  output adc_ctrl_pkg::analog_ctl_t       ANALOG_O,
  output logic                            IRQ_O
);
  import adc_ctrl_pkg::*;

  logic [7:0]          control_r;
  logic [7:0]          timing_r;
  logic [9:0]          result_r;
  logic [1:0]          irq_stat_r;
  logic [1:0]          irq_mask_r;
  seq_state_t          state_r;
  logic [5:0]          div_r;
  logic [4:0]          tad_cnt_r;
  logic                tad_tick;
  logic                done_ev;
  logic                hit_ev;
  logic                wr_acc;
  logic                rd_acc;
  logic [7:0]          idx;
  logic                mapped;
  logic                active;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign idx    = PADDR_I[9:2];
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O == 1'b0 ? 1'b0 : PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;
  assign mapped = (PADDR_I[1:0] == 2'b00) && (PADDR_I[11:10] == 2'b00) &&
                  (idx == IDX_CONTROL || idx == IDX_TIMING || idx == IDX_RES_LOW ||
                   idx == IDX_RES_HIGH || idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK);
  // power-down stops everything, idle mode is not seen here
  assign active = control_r[BIT_ON] && !POWER_DOWN_I;

  // zero wait state slave
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // converter clock divider
  // ----------------------------------------------------------------
  assign tad_tick = (div_r == tad_cycles(timing_r[7:BIT_TSEL]) - 6'd1);

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      div_r <= 6'd0;
    end else if (state_r == ST_IDLE || tad_tick) begin
      div_r <= 6'd0;
    end else begin
      div_r <= div_r + 6'd1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic run_set;
  logic run_clr_sw;
  assign run_set    = wr_acc && PREADY_O && mapped && idx == IDX_CONTROL && PSTRB_I[0] && PWDATA_I[BIT_RUN];
  assign run_clr_sw = wr_acc && PREADY_O && mapped && idx == IDX_CONTROL && PSTRB_I[0] && !PWDATA_I[BIT_RUN];

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_r   <= ST_IDLE;
      tad_cnt_r <= 5'd0;
    end else if (!active || !control_r[BIT_RUN] || run_clr_sw) begin
      state_r   <= ST_IDLE;
      tad_cnt_r <= 5'd0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_r   <= ST_SAMPLE;
          tad_cnt_r <= 5'd0;
        end
        ST_SAMPLE: begin
          if (tad_tick) begin
            if (tad_cnt_r == sample_tads(timing_r[3:0]) - 5'd1) begin
              state_r   <= ST_CONV;
              tad_cnt_r <= 5'd0;
            end else begin
              tad_cnt_r <= tad_cnt_r + 5'd1;
            end
          end
        end
        ST_CONV: begin
          if (tad_tick) begin
            if (tad_cnt_r == {1'b0, CONVERT_TADS} - 5'd1) begin
              state_r   <= control_r[BIT_CMP] ? ST_SAMPLE : ST_IDLE;
              tad_cnt_r <= 5'd0;
            end else begin
              tad_cnt_r <= tad_cnt_r + 5'd1;
            end
          end
        end
        default: begin
          state_r   <= ST_IDLE;
          tad_cnt_r <= 5'd0;
        end
      endcase
    end
  end

  logic conv_end;
  assign conv_end = active && control_r[BIT_RUN] && !run_clr_sw && state_r == ST_CONV && tad_tick &&
                    tad_cnt_r == {1'b0, CONVERT_TADS} - 5'd1;
  assign done_ev  = conv_end && !control_r[BIT_CMP];
  assign hit_ev   = conv_end && control_r[BIT_CMP] && (CORE_RESULT_I > result_r);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic wr_ok;
  assign wr_ok = wr_acc && PREADY_O && mapped;

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      control_r <= CONTROL_RESET;
    end else begin
      if (wr_ok && idx == IDX_CONTROL && PSTRB_I[0]) begin
        control_r <= PWDATA_I[7:0];
      end
      // hardware set wins over a software clear in the same cycle
      if (done_ev || hit_ev) begin
        control_r[BIT_IRQ] <= 1'b1;
      end
      if (done_ev && !run_set) begin
        control_r[BIT_RUN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      timing_r <= TIMING_RESET;
    end else if (wr_ok && idx == IDX_TIMING && PSTRB_I[0]) begin
      timing_r <= PWDATA_I[7:0] & TIMING_WMASK;
    end
  end

  // result pair doubles as the compare value
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      result_r <= 10'h000;
    end else if (done_ev) begin
      result_r <= CORE_RESULT_I;
    end else begin
      if (wr_ok && idx == IDX_RES_HIGH && PSTRB_I[0]) begin
        result_r[9:2] <= PWDATA_I[7:0];
      end
      if (wr_ok && idx == IDX_RES_LOW && PSTRB_I[0]) begin
        result_r[1:0] <= PWDATA_I[1:0];
      end
    end
  end

  // sticky status, cleared by a read; a new event wins
  // only bits already captured in read data are cleared, so an event landing after the setup edge stays pending
  logic [1:0] stat_clr;
  assign stat_clr = (rd_acc && PREADY_O && mapped && idx == IDX_IRQ_STAT) ? PRDATA_O[1:0] : 2'b00;

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_stat_r <= 2'b00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | {hit_ev, done_ev};
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_mask_r <= 2'b00;
    end else if (wr_ok && idx == IDX_IRQ_MASK && PSTRB_I[0]) begin
      irq_mask_r <= PWDATA_I[1:0];
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // read data, registered in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      case (idx)
        IDX_CONTROL:  PRDATA_O <= {24'h00_0000, control_r};
        IDX_TIMING:   PRDATA_O <= {24'h00_0000, timing_r};
        IDX_RES_LOW:  PRDATA_O <= {30'h0000_0000, result_r[1:0]};
        IDX_RES_HIGH: PRDATA_O <= {24'h00_0000, result_r[9:2]};
        IDX_IRQ_STAT: PRDATA_O <= {30'h0000_0000, irq_stat_r};
        IDX_IRQ_MASK: PRDATA_O <= {30'h0000_0000, irq_mask_r};
        default:      PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // analog front end
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ANALOG_O <= '0;
    end else begin
      ANALOG_O.power   <= active;
      ANALOG_O.ext_ref <= control_r[BIT_REF];
      ANALOG_O.channel <= control_r[3:BIT_CHLO];
      // input three is lost to the reference pin; sampling it is suppressed
      // gated by active so that a switch-off never leaves one sample or step cycle without power
      ANALOG_O.sample  <= active && state_r == ST_SAMPLE &&
                          !(control_r[BIT_REF] && control_r[3:BIT_CHLO] == CHANNEL_THREE);
      ANALOG_O.step    <= active && state_r == ST_CONV && tad_tick;
    end
  end

endmodule // sar_adc_control

// ==== adc_ctrl_pkg.sv ====
// constants, register layout and types for the converter control block
// assumes an APB master on the CPU side and a SAR core with a simple step interface
//
// Contract
// - converter runs only while converter_on is 1, otherwise held disabled
// - irq flag set on completion or compare hit, stays until software writes 0
// - compare_enable 1 selects compare operation, 0 single conversion
// - reference_select 0 uses supply, 1 uses external reference pin
// - channel_select bits 3..1 route input n for code n
// - software writes run bit 1 to start; device starts selected operation
// - normal mode clears run bit when conversion finishes
// - writing run bit 0 during conversion aborts it
// - compare mode never clears run bit by hardware
// - external reference takes analog_input_three pin, input 3 unavailable
// - clock period code 0..7 gives 2,4,6,8,12,16,24,32 system clocks
// - sample phase lasts field value plus one converter clocks
// - sample phase clamped between 2 and 15 converter clocks
// - conversion takes 12 converter clocks after sampling
// - result bits 9..2 to high byte, 1..0 to low byte; compare value there too
// - keeps running in idle mode, disabled in power-down mode
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map (printed offsets are indices, byte address = 4*index)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_CONTROL   = 8'h93;
  localparam logic [7:0]  IDX_TIMING    = 8'h94;
  localparam logic [7:0]  IDX_RES_LOW   = 8'h96;
  localparam logic [7:0]  IDX_RES_HIGH  = 8'h97;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'hA0;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'hA1;

  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  TIMING_RESET  = 8'h00;
  localparam logic [7:0]  TIMING_WMASK  = 8'hEF;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int BIT_ON   = 7;
  localparam int BIT_IRQ  = 6;
  localparam int BIT_CMP  = 5;
  localparam int BIT_REF  = 4;
  localparam int BIT_CHLO = 1;
  localparam int BIT_RUN  = 0;
  localparam int BIT_TSEL = 5;

  // ----------------------------------------------------------------
  // timing counts in converter clocks
  // ----------------------------------------------------------------
  localparam logic [4:0]  SAMPLE_MIN    = 5'd2;
  localparam logic [4:0]  SAMPLE_MAX    = 5'd15;
  localparam logic [3:0]  CONVERT_TADS  = 4'd12;
  localparam logic [2:0]  CHANNEL_THREE = 3'd3;
  localparam int          RESULT_W      = 10;

  // irq status bits: 0 conversion done, 1 compare hit
  localparam int EV_DONE = 0;
  localparam int EV_HIT  = 1;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } seq_state_t;

  // analog front end controls
  typedef struct packed {
    logic       power;
    logic       ext_ref;
    logic [2:0] channel;
    logic       sample;
    logic       step;
  } analog_ctl_t;

  // converter clock divide, in system clocks
  function automatic logic [5:0] tad_cycles(input logic [2:0] code);
    case (code)
      3'd0:    tad_cycles = 6'd2;
      3'd1:    tad_cycles = 6'd4;
      3'd2:    tad_cycles = 6'd6;
      3'd3:    tad_cycles = 6'd8;
      3'd4:    tad_cycles = 6'd12;
      3'd5:    tad_cycles = 6'd16;
      3'd6:    tad_cycles = 6'd24;
      default: tad_cycles = 6'd32;
    endcase
  endfunction

  function automatic logic [4:0] sample_tads(input logic [3:0] ts);
    logic [4:0] n;
    n = {1'b0, ts} + 5'd1;
    if (n < SAMPLE_MIN) n = SAMPLE_MIN;
    if (n > SAMPLE_MAX) n = SAMPLE_MAX;
    sample_tads = n;
  endfunction

endpackage

// ==== sar_adc_control_checker.sv ====
// assertions on the converter control block ports
// bound to every instance of the control block at the foot of this file
`timescale 1ns/10ps
module sar_adc_control_checker (
  input wire logic                      CLOCK_I,
  input wire logic                      SYS_RST_I,
  input wire logic                      PSEL_I,
  input wire logic                      PENABLE_I,
  input wire logic                      PREADY_O,
  input wire logic                      PSLVERR_O,
  input wire logic                      POWER_DOWN_I,
  input wire adc_ctrl_pkg::analog_ctl_t ANALOG_O,
  input wire logic                      IRQ_O
);
  import adc_ctrl_pkg::*;
  logic [4:0] steps_r;
  wire        ch3_ext = ANALOG_O.ext_ref && (ANALOG_O.channel == CHANNEL_THREE);
  default clocking dc @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  // steps seen since the last sample phase or the last cycle with input three on the external reference
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) steps_r <= 5'h00;
    else if (ANALOG_O.sample || ch3_ext) steps_r <= 5'h00;
    else if (ANALOG_O.step) steps_r <= steps_r + 5'h01;
  end
  off_idle_a: assert property ((ANALOG_O.sample || ANALOG_O.step) |-> ANALOG_O.power)
    else $error("converter active while off");
  pd_halt_a: assert property (POWER_DOWN_I [*2] |-> !ANALOG_O.step)
    else $error("step during power-down");
  step_gap_a: assert property (ANALOG_O.step |=> !ANALOG_O.step)
    else $error("converter clock shorter than two cycles");
  ref_pin_a: assert property (ch3_ext |-> !ANALOG_O.sample)
    else $error("input three sampled with external reference");
  sample_min_a: assert property ($rose(ANALOG_O.sample) |=> ANALOG_O.sample [*3])
    else $error("sample phase too short");
  step_count_a: assert property (steps_r <= 5'h0c)
    else $error("more than twelve steps per conversion");
  step_phase_a: assert property (ANALOG_O.step |-> !ANALOG_O.sample)
    else $error("step inside sample phase");
  ready_slot_a: assert property ((PSEL_I && !PENABLE_I) |=> PREADY_O)
    else $error("no ready in access cycle");
  err_slot_a: assert property (PSLVERR_O |-> PREADY_O && PSEL_I && PENABLE_I)
    else $error("error outside access cycle");
  cover property (steps_r == 5'h0c);
  cover property ($rose(IRQ_O));
  cover property (PSLVERR_O);
endmodule // sar_adc_control_checker

bind sar_adc_control sar_adc_control_checker i_sar_adc_control_checker (.CLOCK_I, .SYS_RST_I, .PSEL_I,
  .PENABLE_I, .PREADY_O, .PSLVERR_O, .POWER_DOWN_I, .ANALOG_O, .IRQ_O);

// ==== sar_core_model.sv ====
// analog input mux and sar core model: one fixed result per channel
// assumes the control block samples the result only at the end of conversion
`timescale 1ns/10ps
module sar_core_model (
  input  wire adc_ctrl_pkg::analog_ctl_t analog_i,
  output logic [9:0]                     result_o
);
  import adc_ctrl_pkg::*;
  // a powered-off core shows a pattern, not a held value
  assign result_o = analog_i.power ? {analog_i.channel, 7'h55} : 10'h2aa;
endmodule // sar_core_model

// ==== testbench.sv ====
// self-checking bench for the converter control block
// assumes zero-wait APB answers and the core model result {channel, 0x55}
`timescale 1ns/10ps
module testbench;
  import adc_ctrl_pkg::*;
  localparam logic [11:0] a_ctl = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [11:0] a_tim = {2'b00, IDX_TIMING, 2'b00};
  localparam logic [11:0] a_rl  = {2'b00, IDX_RES_LOW, 2'b00};
  localparam logic [11:0] a_rh  = {2'b00, IDX_RES_HIGH, 2'b00};
  localparam logic [11:0] a_st  = {2'b00, IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] a_msk = {2'b00, IDX_IRQ_MASK, 2'b00};
  localparam int          tad_tab [8] = '{2, 4, 6, 8, 12, 16, 24, 32};
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pdown = 1'b0;
  logic        serr, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, q, prdata;
  logic [9:0]  core_res;
  logic [3:0]  tsv;
  logic [3:0]  pstrb = 4'h1;
  logic [2:0]  ch_seen;
  analog_ctl_t ana;
  int          err_total = 0, num_checks = 0, s_cnt = 0, t_cnt = 0, s0, t0, smp;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (ana.sample) s_cnt++;
    if (ana.sample) ch_seen = ana.channel;
    if (ana.step) t_cnt++;
  end
  sar_adc_control i_sar_adc_control (.CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .POWER_DOWN_I(pdown), .CORE_RESULT_I(core_res), .ANALOG_O(ana), .IRQ_O(irq));
  sar_core_model i_sar_core_model (.analog_i(ana), .result_o(core_res));
  task automatic test_done;
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("ready", n < 16, 1'b1);
    if (n >= 16) test_done;
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, a_ctl, 8'h00);
    chk("control reset", q, 8'h00);
    apb(1'b0, a_tim, 8'h00);
    chk("timing reset", q, 8'h00);
    apb(1'b1, a_tim, 8'hff);
    apb(1'b0, a_tim, 8'h00);
    chk("timing readback", q, 8'hef);
    pstrb <= 4'h0;
    apb(1'b1, a_tim, 8'h20);
    pstrb <= 4'h1;
    apb(1'b0, a_tim, 8'h00);
    chk("strobe off", q, 8'hef);
    apb(1'b0, 12'h000, 8'h00);
    chk("unmapped", {serr, q[30:0]}, 32'h8000_0000);
    apb(1'b1, a_msk, 8'h01);
    for (int i = 0; i < 8; i++) begin
      tsv = (i == 7) ? 4'hf : 4'(2 * i);
      smp = (tsv == 0) ? 2 : ((tsv == 15) ? 15 : tsv + 1);
      apb(1'b1, a_tim, {i[2:0], 1'b0, tsv});
      s0 = s_cnt;
      t0 = t_cnt;
      apb(1'b1, a_ctl, {4'h8, i[2:0], 1'b1});
      for (int n = 0; n < 400 && (n == 0 || q[BIT_RUN] !== 1'b0); n++) apb(1'b0, a_ctl, 8'h00);
      chk("done control", q, {4'hc, i[2:0], 1'b0});
      chk("sample clocks", s_cnt - s0, tad_tab[i] * smp);
      chk("convert steps", t_cnt - t0, 12);
      chk("channel", ch_seen, i[2:0]);
      apb(1'b0, a_rh, 8'h00);
      chk("result high", q, {i[2:0], 5'h15});
      apb(1'b0, a_rl, 8'h00);
      chk("result low", q, 8'h01);
      chk("irq done", irq, 1'b1);
      apb(1'b0, a_st, 8'h00);
      chk("status done", q, 8'h01);
      apb(1'b1, a_ctl, 8'h80);
      chk("irq cleared", irq, 1'b0);
    end
    apb(1'b1, a_tim, 8'hef);
    t0 = t_cnt;
    apb(1'b1, a_ctl, 8'h81);
    repeat (8) @(posedge clk);
    apb(1'b1, a_ctl, 8'h80);
    repeat (600) @(posedge clk);
    apb(1'b0, a_ctl, 8'h00);
    chk("abort", {q[7:0], 8'(t_cnt - t0)}, 16'h8000);
    apb(1'b1, a_tim, 8'h00);
    s0 = s_cnt;
    apb(1'b1, a_ctl, 8'h01);
    repeat (40) @(posedge clk);
    chk("off idle", s_cnt - s0 + t_cnt - t0, 0);
    chk("off power", ana.power, 1'b0);
    pdown <= 1'b1;
    apb(1'b1, a_ctl, 8'h81);
    repeat (40) @(posedge clk);
    chk("power-down", s_cnt - s0 + t_cnt - t0, 0);
    chk("power-down off", ana.power, 1'b0);
    apb(1'b1, a_ctl, 8'h80);
    pdown <= 1'b0;
    s0 = s_cnt;
    apb(1'b1, a_ctl, 8'h97);
    repeat (20) @(posedge clk);
    chk("ext reference", ana.ext_ref, 1'b1);
    chk("input three", s_cnt - s0, 0);
    apb(1'b1, a_ctl, 8'h80);
    apb(1'b1, a_msk, 8'h00);
    apb(1'b1, a_rh, 8'hff);
    apb(1'b1, a_rl, 8'h03);
    t0 = t_cnt;
    apb(1'b1, a_ctl, 8'ha1);
    repeat (100) @(posedge clk);
    apb(1'b0, a_ctl, 8'h00);
    chk("compare miss", q, 8'ha1);
    chk("compare repeats", t_cnt - t0 > 24, 1'b1);
    apb(1'b1, a_rh, 8'h00);
    repeat (40) @(posedge clk);
    apb(1'b0, a_ctl, 8'h00);
    chk("compare hit", q, 8'he1);
    chk("hit masked", irq, 1'b0);
    apb(1'b1, a_ctl, 8'h80);
    apb(1'b1, a_msk, 8'h02);
    apb(1'b0, a_rh, 8'h00);
    chk("compare value", q, 8'h00);
    chk("hit unmasked", irq, 1'b1);
    apb(1'b0, a_st, 8'h00);
    chk("status hit", q & 32'h0000_0002, 8'h02);
    apb(1'b0, a_st, 8'h00);
    chk("status clear", q, 8'h00);
    test_done;
  end
endmodule // testbench
